// File: core/byte_arith_skip_jump_regs.vh
`ifndef BYTE_ARITH_SKIP_JUMP_REGS_VH
`define BYTE_ARITH_SKIP_JUMP_REGS_VH
// Operation select codes
`define OP_W                 3
`define OP_IDLE              3'h0
`define OP_DECIMAL_ADJUST    3'h1
`define OP_DECREMENT         3'h2
`define OP_INCREMENT         3'h3
`define OP_DEC_SKIP_ZERO     3'h4
`define OP_DEC_SKIP_NONZERO  3'h5
`define OP_INC_SKIP_ZERO     3'h6
`define OP_INC_SKIP_NONZERO  3'h7
// Decimal adjust constants
`define BCD_LIMIT            4'h9
`define BCD_CORRECTION       4'h6
// Destination select value for register write-back
`define DEST_REGISTER        1'b1
// Program counter layout
`define PC_W                 21
`define JUMP_TARGET_W        20
`endif

// File: core/skip_squash_counter.v
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Squash counter: marks fetched words to be discarded
// ************************************************************
module skip_squash_counter (
    input  wire       ref_clk_i,
    input  wire       srst_i,
    input  wire       load_i,
    input  wire [1:0] load_count_i,
    input  wire       advance_i,
    output wire       squash_o
);
    reg  [1:0] count_reg;
    reg  [1:0] count_next;

    // Next count: load wins over advance
    always @* begin
        count_next = count_reg;
        if (load_i) begin
            count_next = load_count_i;
        end else if (advance_i && (count_reg != 2'h0)) begin
            count_next = count_reg - 2'h1;
        end
    end

    // Count register
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            count_reg <= 2'h0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Squash while discarded words remain
    assign squash_o = (count_reg != 2'h0);
endmodule
`default_nettype wire

// File: core/byte_arith_skip_jump_exec.v
`timescale 1ns/1ns
`default_nettype none
`include "byte_arith_skip_jump_regs.vh"
// ************************************************************
// Execute stage for byte arithmetic, skips and absolute jump
// ************************************************************
module byte_arith_skip_jump_exec (
    input  wire                      ref_clk_i,
    input  wire                      srst_i,
    input  wire                      issue_i,
    input  wire [`OP_W-1:0]          op_i,
    input  wire                      dest_i,
    input  wire [7:0]                reg_value_i,
    input  wire [7:0]                accum_i,
    input  wire                      carry_i,
    input  wire                      half_carry_flag_i,
    input  wire                      jump_i,
    input  wire [7:0]                jump_low_i,
    input  wire                      word_i,
    input  wire [11:0]               word_value_i,
    input  wire                      next_is_two_word_i,
    output reg                       accum_we_o,
    output reg  [7:0]                accum_o,
    output reg                       reg_we_o,
    output reg  [7:0]                reg_o,
    output reg                       carry_we_o,
    output reg                       carry_o,
    output reg                       pc_we_o,
    output reg  [`PC_W-1:0]          program_counter_o,
    output wire                      idle_instruction_o,
    output wire                      busy_o
);
    // ********************************************************
    // States
    // ********************************************************
    localparam ST_RUN  = 2'b01;
    localparam ST_JUMP = 2'b10;

    // ********************************************************
    // Internal signals
    // ********************************************************
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [7:0]  jump_low_reg;
    reg  [7:0]  jump_low_next;
    reg  [7:0]  result;
    reg  [7:0]  adj;
    reg         adj_carry;
    reg         skip_take;
    wire        squash;

    // ********************************************************
    // Decimal adjust
    // ********************************************************
    // Nibble tests use the incoming byte, not the corrected one
    // Low nibble carry ripples into the high nibble sum
    // Incoming carry kept, so carry is never cleared here
    // Decimal adjust of one byte, returns carry in bit 8
    function [8:0] decimal_adjust;
        input [7:0] value;
        input       c;
        input       hc;
        reg   [4:0] lo;
        reg   [4:0] hi;
        begin
            lo = {1'b0, value[3:0]};
            if ((value[3:0] > `BCD_LIMIT) || hc) begin
                lo = lo + {1'b0, `BCD_CORRECTION};
            end
            hi = {1'b0, value[7:4]} + {4'h0, lo[4]};
            if ((value[7:4] > `BCD_LIMIT) || c) begin
                hi = hi + {1'b0, `BCD_CORRECTION};
            end
            decimal_adjust = {hi[4] | c | (value[7:4] > `BCD_LIMIT), hi[3:0], lo[3:0]};
        end
    endfunction

    // ********************************************************
    // Operation decode
    // ********************************************************
    // Operands are same-cycle inputs, so result is combinational
    // Skip on zero or nonzero result, chosen by op code
    // Unused codes fall back to the adjusted byte
    // Operation result and skip decision
    always @* begin
        {adj_carry, adj} = decimal_adjust(accum_i, carry_i, half_carry_flag_i);
        case (op_i)
            `OP_DECREMENT, `OP_DEC_SKIP_ZERO, `OP_DEC_SKIP_NONZERO: begin
                result = reg_value_i - 8'h01;
            end
            `OP_INCREMENT, `OP_INC_SKIP_ZERO, `OP_INC_SKIP_NONZERO: begin
                result = reg_value_i + 8'h01;
            end
            default: begin
                result = adj;
            end
        endcase
        case (op_i)
            `OP_DEC_SKIP_ZERO, `OP_INC_SKIP_ZERO: skip_take = (result == 8'h00);
            `OP_DEC_SKIP_NONZERO, `OP_INC_SKIP_NONZERO: begin
                skip_take = (result != 8'h00);
            end
            default: skip_take = 1'b0;
        endcase
    end

    // ********************************************************
    // Issue acceptance
    // ********************************************************
    // Requests during squash or pending jump dropped silently
    // Issue has priority over a jump in the same cycle
    wire exec_ok  = (state_reg == ST_RUN) && !squash && issue_i;
    wire arith_ok = exec_ok && (op_i != `OP_IDLE);
    wire do_skip  = arith_ok && skip_take;
    wire do_jump  = (state_reg == ST_RUN) && !squash && jump_i && !issue_i;

    // ********************************************************
    // Squash control
    // ********************************************************
    // Squash ends by fetched-word count, not elapsed cycles
    // Fetch stalls simply stretch the squash window
    // Load beats advance if skip and word coincide
    // Discards one word, or two when a two-word instruction follows
    skip_squash_counter u_squash (
        .ref_clk_i    (ref_clk_i),
        .srst_i       (srst_i),
        .load_i       (do_skip),
        .load_count_i (next_is_two_word_i ? 2'h2 : 2'h1),
        .advance_i    (word_i),
        .squash_o     (squash)
    );

    // ********************************************************
    // Jump sequencing
    // ********************************************************
    // Low literal held until the upper word arrives
    // Second word always consumed; ST_JUMP holds until word_i brings it
    // State and captured low literal
    always @* begin
        state_next    = state_reg;
        jump_low_next = jump_low_reg;
        case (state_reg)
            ST_RUN: begin
                if (do_jump) begin
                    jump_low_next = jump_low_i;
                    state_next    = ST_JUMP;
                end
            end
            ST_JUMP: begin
                if (word_i) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    // State and literal registers
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg    <= ST_RUN;
            jump_low_reg <= 8'h00;
        end else begin
            state_reg    <= state_next;
            jump_low_reg <= jump_low_next;
        end
    end

    // ********************************************************
    // Write-back
    // ********************************************************
    // Both data outputs carry the result; strobes pick target
    // Decimal adjust ignores destination bit, writes accumulator
    // Program counter bit 0 stays zero, words are two bytes
    // Data held between strobes, only strobes pulse
    // Registered write-back strobes and data
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            accum_we_o        <= 1'b0;
            accum_o           <= 8'h00;
            reg_we_o          <= 1'b0;
            reg_o             <= 8'h00;
            carry_we_o        <= 1'b0;
            carry_o           <= 1'b0;
            pc_we_o           <= 1'b0;
            program_counter_o <= {`PC_W{1'b0}};
        end else begin
            accum_we_o <= arith_ok && ((op_i == `OP_DECIMAL_ADJUST) ||
                          (dest_i != `DEST_REGISTER));
            reg_we_o   <= arith_ok && (op_i != `OP_DECIMAL_ADJUST) &&
                          (dest_i == `DEST_REGISTER);
            carry_we_o <= arith_ok && (op_i == `OP_DECIMAL_ADJUST);
            pc_we_o    <= (state_reg == ST_JUMP) && word_i;
            if (arith_ok) begin
                accum_o <= result;
                reg_o   <= result;
            end
            if (arith_ok && (op_i == `OP_DECIMAL_ADJUST)) begin
                carry_o <= adj_carry;
            end
            if ((state_reg == ST_JUMP) && word_i) begin
                program_counter_o <= {word_value_i, jump_low_reg, 1'b0};
            end
        end
    end

    // ********************************************************
    // Status outputs
    // ********************************************************
    // Idle covers squashed words and the jump's second cycle
    // Busy marks only the pending second jump word
    assign idle_instruction_o = squash || (state_reg == ST_JUMP);
    assign busy_o             = (state_reg == ST_JUMP);
endmodule
`default_nettype wire

// File: testbench/byte_arith_skip_jump_exec_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module byte_arith_skip_jump_exec_asserts (
    input wire logic        ref_clk_i, srst_i, issue_i, dest_i, jump_i, word_i,
    input wire logic        next_is_two_word_i, accum_we_o, reg_we_o, carry_we_o, carry_o,
    input wire logic        pc_we_o, idle_instruction_o, busy_o,
    input wire logic [2:0]  op_i,
    input wire logic [7:0]  reg_value_i, accum_i, jump_low_i, accum_o, reg_o,
    input wire logic [11:0] word_value_i,
    input wire logic [20:0] program_counter_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Accepted arithmetic issue and accepted jump
    wire arith = issue_i && !idle_instruction_o;
    wire jmp   = jump_i && !issue_i && !idle_instruction_o;
    dec_to_reg_a: assert property (arith && op_i == 3'h2 && dest_i |=>
        reg_we_o && !accum_we_o && reg_o == $past(reg_value_i) - 8'h01) else $error("dec bad");
    inc_to_acc_a: assert property (arith && op_i == 3'h3 && !dest_i |=>
        accum_we_o && !reg_we_o && accum_o == $past(reg_value_i) + 8'h01) else $error("inc bad");
    adjust_flags_a: assert property (arith && op_i == 3'h1 |=>
        accum_we_o && carry_we_o && !reg_we_o) else $error("adjust writes bad");
    adjust_carry_a: assert property (arith && op_i == 3'h1 && accum_i[7:4] > 4'h9 |=>
        carry_o) else $error("adjust carry bad");
    skip_taken_a: assert property (arith && op_i == 3'h5 && reg_value_i != 8'h01 |=>
        idle_instruction_o) else $error("skip missing");
    skip_none_a: assert property (arith && op_i == 3'h5 && reg_value_i == 8'h01 |=>
        !idle_instruction_o) else $error("false skip");
    jump_target_a: assert property (jmp ##1 word_i |=> pc_we_o &&
        program_counter_o == {$past(word_value_i), $past(jump_low_i, 2), 1'b0}) else $error("pc bad");
    jump_two_a: assert property (jmp |=> busy_o && idle_instruction_o && !pc_we_o)
        else $error("jump cycle bad");
    skip_long_a: assert property (arith && op_i == 3'h5 && reg_value_i != 8'h01 &&
        next_is_two_word_i ##1 word_i |=> idle_instruction_o) else $error("long skip bad");
endmodule
bind byte_arith_skip_jump_exec byte_arith_skip_jump_exec_asserts chk_u (
    .ref_clk_i          (ref_clk_i),
    .srst_i             (srst_i),
    .issue_i            (issue_i),
    .dest_i             (dest_i),
    .jump_i             (jump_i),
    .word_i             (word_i),
    .next_is_two_word_i (next_is_two_word_i),
    .accum_we_o         (accum_we_o),
    .reg_we_o           (reg_we_o),
    .carry_we_o         (carry_we_o),
    .carry_o            (carry_o),
    .pc_we_o            (pc_we_o),
    .idle_instruction_o (idle_instruction_o),
    .busy_o             (busy_o),
    .op_i               (op_i),
    .reg_value_i        (reg_value_i),
    .accum_i            (accum_i),
    .jump_low_i         (jump_low_i),
    .accum_o            (accum_o),
    .reg_o              (reg_o),
    .word_value_i       (word_value_i),
    .program_counter_o  (program_counter_o)
);
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk_i = 0, srst_i = 1, issue_i = 0, dest_i = 0, carry_i = 0;
    logic half_carry_flag_i = 0, jump_i = 0, word_i = 0, next_is_two_word_i = 0;
    logic [2:0] op_i = 0;
    logic [7:0] reg_value_i = 0, accum_i = 0, jump_low_i = 0, qa[$], qr[$], qc[$];
    logic [11:0] word_value_i = 0;
    logic [20:0] qp[$];
    wire accum_we_o, reg_we_o, carry_we_o, carry_o, pc_we_o, idle_instruction_o, busy_o;
    wire [7:0] accum_o, reg_o;
    wire [20:0] program_counter_o;
    int fail_count = 0, comparisons = 0;
    integer seed = 32'he827;
    logic [31:0] rv;
    byte_arith_skip_jump_exec dut_u (
        .ref_clk_i          (ref_clk_i),
        .srst_i             (srst_i),
        .issue_i            (issue_i),
        .op_i               (op_i),
        .dest_i             (dest_i),
        .reg_value_i        (reg_value_i),
        .accum_i            (accum_i),
        .carry_i            (carry_i),
        .half_carry_flag_i  (half_carry_flag_i),
        .jump_i             (jump_i),
        .jump_low_i         (jump_low_i),
        .word_i             (word_i),
        .word_value_i       (word_value_i),
        .next_is_two_word_i (next_is_two_word_i),
        .accum_we_o         (accum_we_o),
        .accum_o            (accum_o),
        .reg_we_o           (reg_we_o),
        .reg_o              (reg_o),
        .carry_we_o         (carry_we_o),
        .carry_o            (carry_o),
        .pc_we_o            (pc_we_o),
        .program_counter_o  (program_counter_o),
        .idle_instruction_o (idle_instruction_o),
        .busy_o             (busy_o)
    );
    initial forever #10 ref_clk_i = ~ref_clk_i;
    task automatic cmp_pc(input logic [20:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, exp);
        cmp_pc({13'h0, got}, {13'h0, exp});
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Result monitor, oldest note first
    always @(negedge ref_clk_i) if (!srst_i) begin
        if (accum_we_o !== 1'b0) cmp_byte(accum_o, qa.pop_front());
        if (reg_we_o !== 1'b0) cmp_byte(reg_o, qr.pop_front());
        if (carry_we_o !== 1'b0) cmp_byte({7'h0, carry_o}, qc.pop_front());
        if (pc_we_o !== 1'b0) cmp_pc(program_counter_o, qp.pop_front());
    end
    // One arithmetic issue followed by its fetched word(s)
    task automatic run(input logic [2:0] o, input logic d, input logic [7:0] r, a,
                       input logic c, h, t);
        logic [7:0] res, v;
        logic sk;
        res = (o == 3'h3 || o[2:1] == 2'b11) ? r + 8'h01 : r - 8'h01;
        sk = o[2] && ((res == 8'h00) ^ o[0]);
        @(negedge ref_clk_i);
        {op_i, dest_i, reg_value_i, accum_i, carry_i, half_carry_flag_i} = {o, d, r, a, c, h};
        next_is_two_word_i = t;
        issue_i = 1;
        v = a + ((a[3:0] > 4'h9 || h) ? 8'h06 : 8'h00);
        if (o == 3'h1) begin
            qa.push_back(v + ((a[7:4] > 4'h9 || c) ? 8'h60 : 8'h00));
            qc.push_back({7'h0, a[7:4] > 4'h9 || c});
        end else if (o != 3'h0) begin
            if (d) qr.push_back(res);
            else qa.push_back(res);
        end
        @(negedge ref_clk_i);
        issue_i = 0;
        word_i = 1;
        #1 cmp_byte({7'h0, idle_instruction_o}, {7'h0, sk});
        if (sk && t) begin
            @(negedge ref_clk_i);
            #1 cmp_byte({7'h0, idle_instruction_o}, 8'h01);
        end
        @(negedge ref_clk_i);
        word_i = 0;
    endtask
    // Two-word absolute jump
    task automatic jump(input logic [19:0] k);
        @(negedge ref_clk_i);
        jump_i = 1;
        jump_low_i = k[7:0];
        qp.push_back({k, 1'b0});
        @(negedge ref_clk_i);
        {jump_i, word_i, word_value_i} = {1'b0, 1'b1, k[19:8]};
        #1 cmp_byte({7'h0, busy_o}, 8'h01);
        @(negedge ref_clk_i);
        {word_i, word_value_i} = {1'b0, ~k[19:8]};
    endtask
    // Issue and jump offered during a squash must be dropped
    task automatic refused;
        @(negedge ref_clk_i);
        {op_i, dest_i, reg_value_i, next_is_two_word_i, issue_i} = {3'h5, 1'h1, 8'h10, 1'h0, 1'h1};
        qr.push_back(8'h0F);
        @(negedge ref_clk_i);
        {op_i, reg_value_i, word_i, jump_i} = {3'h3, 8'h20, 1'h1, 1'h1};
        #1 cmp_byte({7'h0, idle_instruction_o}, 8'h01);
        @(negedge ref_clk_i);
        {issue_i, word_i, jump_i} = 3'h0;
        #1 cmp_byte({6'h0, busy_o, idle_instruction_o}, 8'h00);
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        fail_count++;
        summarize;
    end
    initial begin
        repeat (10) @(negedge ref_clk_i);
        srst_i = 0;
        run(3'h1, 0, 8'h00, 8'hA5, 0, 0, 0);
        run(3'h1, 1, 8'h00, 8'h12, 0, 1, 0);
        run(3'h1, 0, 8'h00, 8'h40, 1, 0, 0);
        run(3'h1, 0, 8'h00, 8'h3B, 0, 0, 0);
        $display("test decimal adjust done");
        for (int i = 0; i < 64; i++) begin
            rv = $random(seed);
            run(i[2:0], rv[3], i[4:3] == 0 ? 8'h01 : i[4:3] == 1 ? 8'hFF : rv[15:8],
                i[2:0] == 1 ? 8'hCE : rv[23:16], rv[5], rv[6], rv[4]);
        end
        $display("test arithmetic and skip done");
        jump(20'h00000);
        jump(20'hFFFFF);
        jump(20'hABC34);
        $display("test jump done");
        refused();
        $display("test refusal done");
        repeat (3) @(negedge ref_clk_i);
        cmp_byte(8'(qa.size() + qr.size() + qc.size() + qp.size()), 8'h00);
        summarize;
    end
endmodule
`default_nettype wire
